// *** hw/buffered_timer_pkg.sv ***
package buffered_timer_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int PAIRS = 4;
    localparam int CHANNELS = 3;
    localparam int PRE_W = 10;
    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_E = 8'h04;
    localparam logic [7:0] ADDR_CONTROL_F = 8'h08;
    localparam logic [7:0] ADDR_CONTROL_D = 8'h0C;
    localparam logic [7:0] ADDR_EVENT_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_PERIOD_BUFFER = 8'h28;
    localparam logic [7:0] ADDR_STRIDE = 8'h04;
    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CONTROL_A_REG_ENABLE = 0;
    localparam int CONTROL_A_REG_PRESCALE_LSB = 1;
    localparam int CONTROL_E_REG_DIR = 0;
    localparam int CONTROL_E_REG_LOCK_UPDATE = 1;
    localparam int CTRLD_SPLIT = 0;
    localparam int CTRLD_UPDATE_AT_BOTTOM = 1;
    localparam int EVENT_CONTROL_REG_COUNT_ENABLE = 0;
    localparam int EVENT_CONTROL_REG_DIR_ENABLE = 1;
    localparam int EVENT_CONTROL_REG_RESTART_ENABLE = 2;
    localparam int CONTROL_F_REG_PERIOD_VALID = 0;
    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // prescaler masks (divider - 1) for divide by 1,2,4,8,16,64,256,1024
    localparam logic [9:0] PRESCALE_MASK [8] = '{10'h000, 10'h001, 10'h003,
        10'h007, 10'h00F, 10'h03F, 10'h0FF, 10'h3FF};
endpackage

// *** hw/pair_if.sv ***
`timescale 1ns/1ps
interface pair_if;
    logic write_value;
    logic write_buffer;
    logic update;
    logic [15:0] wdata;
    logic [15:0] value;
    logic [15:0] buffer;
    logic valid;
    modport owner (output write_value, write_buffer, update, wdata,
        input value, buffer, valid);
    modport store (input write_value, write_buffer, update, wdata,
        output value, buffer, valid);
endinterface

// *** hw/buffered_pair.sv ***
`timescale 1ns/1ps
module buffered_pair (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // owner side
    pair_if.store port
);
    import buffered_timer_pkg::*;

    // a direct value write bypasses the buffer
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port.value <= COUNT_RESET;
        end else if (port.write_value) begin
            port.value <= port.wdata;
        end else if (port.update && port.valid) begin
            port.value <= port.buffer;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port.buffer <= COUNT_RESET;
        end else if (port.write_buffer) begin
            port.buffer <= port.wdata;
        end
    end

    // set wins over the update clear so a late write is not lost
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            port.valid <= 1'b0;
        end else if (port.write_buffer) begin
            port.valid <= 1'b1;
        end else if (port.update) begin
            port.valid <= 1'b0;
        end
    end
endmodule

// *** hw/timer_prescaler.sv ***
`timescale 1ns/1ps
module timer_prescaler (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // control
    input wire logic i_run,
    input wire logic [2:0] i_select,
    // tick out
    output logic o_tick
);
    import buffered_timer_pkg::*;

    logic [PRE_W-1:0] pre_cnt;
    logic [PRE_W-1:0] mask;

    assign mask = PRESCALE_MASK[i_select];

    // restarts from zero whenever the timer stops
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pre_cnt <= '0;
        end else if (!i_run) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    assign o_tick = i_run && ((pre_cnt & mask) == mask);
endmodule

// *** hw/buffered_timer_counter_base.sv ***
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - counter, period, compares, buffers 16 bits, valid flags
// - split mode gives two 8-bit counters
// - compare counter to zero, period, compares
// - top/bottom/match outputs one cycle later
// - tick from prescaler or event input
// - bottom is counter equal zero, low byte equal zero in split mode
// - top is counter equal period, high byte equal zero in split mode
// - update loads valid buffers unless locked or split
// - enable starts counting at prescaled rate
// - event count enable counts events instead
// - count ticks in direction bit sense
// - up at top wraps to zero
// - down at bottom reloads period
// - counter write is immediate, top priority
// - direction may change while running
// - events give direction and restart
// - period and compares each double-buffered
// - valid flags readable in control F
// - valid set on buffer write, cleared on update
// - loaded compare used from next count
// - unbuffered period applies at once, wraps via max
module buffered_timer_counter_base (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [buffered_timer_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [buffered_timer_pkg::DATA_W-1:0] i_pwdata,
    output logic [buffered_timer_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // event system inputs
    input wire logic i_event_a,
    input wire logic i_event_b,
    input wire logic i_event_sync,
    // event outputs
    output logic o_top_event,
    output logic o_bottom_event,
    output logic [5:0] o_match,
    output logic o_counting_down
);
    import buffered_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // control state
    logic enable;
    logic [2:0] prescale_select;
    logic dir;
    logic lock_update;
    logic split;
    logic update_at_bottom;
    logic event_input_a_count_enable;
    logic event_dir_enable;
    logic event_restart_enable;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    logic setup;
    logic access;
    logic wr;
    logic rd_hit;
    logic [DATA_W-1:0] rd_mux;
    logic [CNT_W-1:0] wdata16;

    logic presc_tick;
    logic tick;
    logic dir_down;
    logic cnt_wr;
    logic restart;
    logic top_hit;
    logic bottom_hit;
    logic upd;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] pair_value [PAIRS];
    logic [CNT_W-1:0] pair_buffer [PAIRS];
    logic [PAIRS-1:0] pair_valid;
    logic [PAIRS-1:0] hit_value;
    logic [PAIRS-1:0] hit_buffer;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign wdata16 = i_pwdata[CNT_W-1:0];
    assign o_pready = 1'b1;
    assign cnt_wr = wr && (i_paddr == ADDR_COUNT);

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = READ_ZERO;
        case (i_paddr)
            ADDR_CONTROL_A: begin
                rd_mux[CONTROL_A_REG_ENABLE] = enable;
                rd_mux[CONTROL_A_REG_PRESCALE_LSB +: 3] = prescale_select;
            end
            ADDR_CONTROL_E: begin
                rd_mux[CONTROL_E_REG_DIR] = dir;
                rd_mux[CONTROL_E_REG_LOCK_UPDATE] = lock_update;
            end
            ADDR_CONTROL_F: begin
                rd_mux[CONTROL_F_REG_PERIOD_VALID +: PAIRS] = pair_valid;
            end
            ADDR_CONTROL_D: begin
                rd_mux[CTRLD_SPLIT] = split;
                rd_mux[CTRLD_UPDATE_AT_BOTTOM] = update_at_bottom;
            end
            ADDR_EVENT_CONTROL: begin
                rd_mux[EVENT_CONTROL_REG_COUNT_ENABLE] = event_input_a_count_enable;
                rd_mux[EVENT_CONTROL_REG_DIR_ENABLE] = event_dir_enable;
                rd_mux[EVENT_CONTROL_REG_RESTART_ENABLE] = event_restart_enable;
            end
            ADDR_COUNT: begin
                rd_mux[CNT_W-1:0] = cnt;
            end
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < PAIRS; i++) begin
                    if (hit_value[i]) begin
                        rd_hit = 1'b1;
                        rd_mux[CNT_W-1:0] = pair_value[i];
                    end
                    if (hit_buffer[i]) begin
                        rd_hit = 1'b1;
                        rd_mux[CNT_W-1:0] = pair_buffer[i];
                    end
                end
            end
        endcase
    end

    // read data and error are sampled in the setup cycle so the access phase
    // completes with no wait state; a running count is seen as of that edge
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= READ_ZERO;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata <= i_pwrite ? READ_ZERO : rd_mux;
            o_pslverr <= !rd_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enable <= 1'b0;
            prescale_select <= 3'h0;
        end else if (wr && i_paddr == ADDR_CONTROL_A) begin
            enable <= i_pwdata[CONTROL_A_REG_ENABLE];
            prescale_select <= i_pwdata[CONTROL_A_REG_PRESCALE_LSB +: 3];
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dir <= 1'b0;
            lock_update <= 1'b0;
        end else if (wr && i_paddr == ADDR_CONTROL_E) begin
            dir <= i_pwdata[CONTROL_E_REG_DIR];
            lock_update <= i_pwdata[CONTROL_E_REG_LOCK_UPDATE];
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            split <= 1'b0;
            update_at_bottom <= 1'b0;
        end else if (wr && i_paddr == ADDR_CONTROL_D) begin
            split <= i_pwdata[CTRLD_SPLIT];
            update_at_bottom <= i_pwdata[CTRLD_UPDATE_AT_BOTTOM];
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            event_input_a_count_enable <= 1'b0;
            event_dir_enable <= 1'b0;
            event_restart_enable <= 1'b0;
        end else if (wr && i_paddr == ADDR_EVENT_CONTROL) begin
            event_input_a_count_enable <= i_pwdata[EVENT_CONTROL_REG_COUNT_ENABLE];
            event_dir_enable <= i_pwdata[EVENT_CONTROL_REG_DIR_ENABLE];
            event_restart_enable <= i_pwdata[EVENT_CONTROL_REG_RESTART_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // period and compare pairs, index 0 is the period
    pair_if pair [PAIRS] ();

    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
        localparam logic [7:0] VAL_ADDR = 8'(ADDR_PERIOD + 8'(g) * ADDR_STRIDE);
        localparam logic [7:0] BUF_ADDR = 8'(ADDR_PERIOD_BUFFER + 8'(g) * ADDR_STRIDE);
        assign hit_value[g] = (i_paddr == VAL_ADDR);
        assign hit_buffer[g] = (i_paddr == BUF_ADDR);
        assign pair[g].write_value = wr && hit_value[g];
        assign pair[g].write_buffer = wr && hit_buffer[g];
        assign pair[g].update = upd;
        assign pair[g].wdata = wdata16;
        assign pair_value[g] = pair[g].value;
        assign pair_buffer[g] = pair[g].buffer;
        assign pair_valid[g] = pair[g].valid;
        buffered_pair u_pair (
            .i_mclk(i_mclk),
            .i_arst_n(i_arst_n),
            .port(pair[g])
        );
    end

    assign per = pair_value[0];

    ////////////////////////////////////////////////////////////////////////////
    // timer clock
    timer_prescaler u_prescaler (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_run(enable && !event_input_a_count_enable),
        .i_select(prescale_select),
        .o_tick(presc_tick)
    );

    assign tick = event_input_a_count_enable ?
        (enable && i_event_a) : presc_tick;
    assign dir_down = event_dir_enable ? i_event_b : dir;
    assign restart = enable && event_restart_enable && i_event_sync;
    assign o_counting_down = dir_down;

    ////////////////////////////////////////////////////////////////////////////
    // counter
    assign top_hit = (cnt == per);
    assign bottom_hit = (cnt == BOTTOM_VALUE);

    // update follows the sequence end, or bottom when so selected
    assign upd = tick && !split && !lock_update &&
        (update_at_bottom ? bottom_hit : (dir_down ? bottom_hit : top_hit));

    always_comb begin
        next_cnt = cnt;
        if (cnt_wr) begin
            next_cnt = wdata16;
        end else if (restart) begin
            next_cnt = (dir_down || split) ? per : BOTTOM_VALUE;
        end else if (tick && split) begin
            next_cnt[7:0] = (cnt[7:0] == 8'h00) ? per[7:0] : cnt[7:0] - 8'h01;
            next_cnt[15:8] = (cnt[15:8] == 8'h00) ? per[15:8] : cnt[15:8] - 8'h01;
        end else if (tick && dir_down) begin
            next_cnt = bottom_hit ? per : cnt - 16'h0001;
        end else if (tick) begin
            // above a freshly lowered top it runs through max and wraps
            next_cnt = top_hit ? BOTTOM_VALUE : cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= COUNT_RESET;
        end else begin
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event outputs, one cycle after the tick that saw the trigger
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_top_event <= 1'b0;
            o_bottom_event <= 1'b0;
        end else if (split) begin
            o_top_event <= tick && cnt[15:8] == 8'h00;
            o_bottom_event <= tick && cnt[7:0] == 8'h00;
        end else begin
            o_top_event <= tick && top_hit;
            o_bottom_event <= tick && bottom_hit;
        end
    end

    for (genvar n = 0; n < CHANNELS; n++) begin : g_match
        logic [CNT_W-1:0] cmp;
        logic lo_hit;
        logic hi_hit;
        assign cmp = pair_value[n+1];
        assign lo_hit = split ? (cnt[7:0] == cmp[7:0]) : (cnt == cmp);
        assign hi_hit = split && (cnt[15:8] == cmp[15:8]);
        always_ff @(posedge i_mclk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                o_match[n] <= 1'b0;
                o_match[n+CHANNELS] <= 1'b0;
            end else begin
                o_match[n] <= tick && lo_hit;
                o_match[n+CHANNELS] <= tick && hi_hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    logic plain_up;
    logic plain_down;
    assign plain_up = tick && !split && !dir_down && !cnt_wr && !restart;
    assign plain_down = tick && !split && dir_down && !cnt_wr && !restart;

    sequence s_period_armed;
        pair[0].write_buffer;
    endsequence

    sequence s_update_fire;
        upd && pair_valid[0] && !pair[0].write_value;
    endsequence

    AST_CNT_WRITE: assert property (cnt_wr |=> cnt == $past(wdata16))
        else $error("counter write not applied at once");

    AST_UP_WRAP: assert property (plain_up && top_hit |=> cnt == BOTTOM_VALUE)
        else $error("counter did not wrap to zero at top");

    AST_UP_STEP: assert property (plain_up && !top_hit |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter did not step up");

    AST_DOWN_RELOAD: assert property (plain_down && bottom_hit |=> cnt == $past(per))
        else $error("counter did not reload period at bottom");

    // the pulse may only stay high when a tick comes in the cycle it is high
    AST_TOP_EVENT: assert property (tick && !split && top_hit |=>
        o_top_event ##1 (!o_top_event || $past(tick)))
        else $error("top event not one cycle after tick");

    AST_MATCH_CAUSE: assert property (o_match[0] |->
        $past(tick && (split ? cnt[7:0] == pair_value[1][7:0] : cnt == pair_value[1])))
        else $error("match pulse without match");

    AST_BUFFER_VALID: assert property (s_period_armed |=> pair_valid[0])
        else $error("period buffer valid not set after write");

    AST_PERIOD_LOAD: assert property (s_update_fire |=> per == $past(pair_buffer[0]))
        else $error("period not loaded from buffer at update");

    AST_LOCK_HOLD: assert property (tick && lock_update && !pair[0].write_value |=>
        $stable(per))
        else $error("period changed while update locked");

    AST_VALID_CLEAR: assert property (upd && !pair[1].write_buffer |=> !pair_valid[1])
        else $error("compare valid not cleared at update");

    AST_IDLE_HOLD: assert property (!enable && !cnt_wr |=> cnt == $past(cnt))
        else $error("counter moved while disabled");

    AST_EVENT_COUNT: assert property (enable && event_input_a_count_enable && !i_event_a &&
        !cnt_wr && !restart |=> $stable(cnt))
        else $error("counter moved without an event");
endmodule

// *** verif/event_source_model.sv ***
`timescale 1ns/1ps
module event_source_model (
    // clock
    input wire logic i_mclk,
    // event lines toward the timer
    output logic o_event_a,
    output logic o_event_b,
    output logic o_event_sync
);
    initial begin
        o_event_a = 1'b0;
        o_event_b = 1'b0;
        o_event_sync = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one-cycle pulses with a quiet cycle between, so every pulse is a separate event
    task automatic send_count(input int n);
        repeat (n) begin
            @(posedge i_mclk) o_event_a <= 1'b1;
            @(posedge i_mclk) o_event_a <= 1'b0;
        end
    endtask
    task automatic send_sync();
        @(posedge i_mclk) o_event_sync <= 1'b1;
        @(posedge i_mclk) o_event_sync <= 1'b0;
    endtask
    // direction is a level, high asks for counting down
    task automatic set_down(input logic down);
        @(posedge i_mclk) o_event_b <= down;
    endtask
endmodule

// *** verif/buffered_timer_counter_base_bench.sv ***
`timescale 1ns/1ps
module buffered_timer_counter_base_bench;
    import buffered_timer_pkg::*;
    logic i_mclk, i_arst_n, i_psel, i_penable, i_pwrite;
    logic [ADDR_W-1:0] i_paddr;
    logic [DATA_W-1:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr, i_event_a, i_event_b, i_event_sync;
    logic o_top_event, o_bottom_event, o_counting_down;
    logic [5:0] o_match;
    int mismatches, total_checks, top_seen, bottom_seen, match_seen, hi_match_seen;
    logic [31:0] rd;
    logic err;

    buffered_timer_counter_base buffered_timer_counter_base_i (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_event_a(i_event_a),
        .i_event_b(i_event_b), .i_event_sync(i_event_sync), .o_top_event(o_top_event),
        .o_bottom_event(o_bottom_event), .o_match(o_match),
        .o_counting_down(o_counting_down));
    event_source_model event_source_model_i (
        .i_mclk(i_mclk), .o_event_a(i_event_a), .o_event_b(i_event_b),
        .o_event_sync(i_event_sync));

    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    // pulse monitors for the one-cycle event outputs
    always @(posedge i_mclk) begin
        if (o_top_event === 1'b1) top_seen++;
        if (o_bottom_event === 1'b1) bottom_seen++;
        if (o_match[0] === 1'b1) match_seen++;
        if (o_match[3] === 1'b1) hi_match_seen++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask
    // setup cycle, then access held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk) i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (o_pready !== 1'b1) begin
            $display("[ERR] pready expected 1 seen %b", o_pready);
            mismatches++;
            results();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1C, 8'h28};
        foreach (addrs[k]) rd_chk("reset value", addrs[k], 32'h0000_0000);
        check("dir after reset", {31'h0, o_counting_down}, 32'h0000_0000);
        rd_chk("unmapped read", 8'h3C, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
    endtask
    task automatic t_buffers();
        wr(8'h28, 32'h0000_0040);
        wr(8'h30, 32'h0000_0011);
        rd_chk("valid flags set", 8'h08, 32'h0000_0005);
        wr(8'h04, 32'h0000_0002);
        wr(8'h00, 32'h0000_0001);
        repeat (4) @(posedge i_mclk);
        rd_chk("locked valid", 8'h08, 32'h0000_0005);
        rd_chk("locked period", 8'h18, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        rd_chk("valid cleared", 8'h08, 32'h0000_0000);
        rd_chk("period loaded", 8'h18, 32'h0000_0040);
        rd_chk("compare loaded", 8'h20, 32'h0000_0011);
        wr(8'h00, 32'h0000_0000);
    endtask
    task automatic t_events();
        int t0;
        wr(8'h14, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        wr(8'h00, 32'h0000_0001);
        event_source_model_i.send_count(5);
        rd_chk("event count", 8'h14, 32'h0000_0005);
        wr(8'h04, 32'h0000_0001);
        event_source_model_i.send_count(2);
        rd_chk("count down", 8'h14, 32'h0000_0003);
        check("dir down", {31'h0, o_counting_down}, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000);
        wr(8'h10, 32'h0000_0003);
        event_source_model_i.set_down(1'b1);
        event_source_model_i.send_count(1);
        rd_chk("event dir", 8'h14, 32'h0000_0002);
        event_source_model_i.set_down(1'b0);
        wr(8'h10, 32'h0000_0001);
        wr(8'h14, 32'h0000_0040);
        rd_chk("count write", 8'h14, 32'h0000_0040);
        t0 = top_seen;
        event_source_model_i.send_count(1);
        rd_chk("wrap at top", 8'h14, 32'h0000_0000);
        check("top pulse", top_seen - t0, 32'h0000_0001);
        wr(8'h04, 32'h0000_0001);
        t0 = bottom_seen;
        event_source_model_i.send_count(1);
        rd_chk("reload at bottom", 8'h14, 32'h0000_0040);
        check("bottom pulse", bottom_seen - t0, 32'h0000_0001);
    endtask
    task automatic t_restart_compare();
        int m0;
        wr(8'h04, 32'h0000_0000);
        wr(8'h10, 32'h0000_0005);
        wr(8'h14, 32'h0000_0007);
        event_source_model_i.send_sync();
        rd_chk("restart", 8'h14, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        wr(8'h1C, 32'h0000_0003);
        wr(8'h14, 32'h0000_0002);
        m0 = match_seen;
        event_source_model_i.send_count(2);
        rd_chk("count past compare", 8'h14, 32'h0000_0004);
        check("match pulse", match_seen - m0, 32'h0000_0001);
        wr(8'h14, 32'h0000_0010);
        wr(8'h18, 32'h0000_0005);
        event_source_model_i.send_count(1);
        rd_chk("period below count", 8'h14, 32'h0000_0011);
    endtask
    task automatic t_prescale_split();
        logic [31:0] c1;
        int h0;
        wr(8'h00, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        wr(8'h18, 32'h0000_FFFF);
        wr(8'h14, 32'h0000_0000);
        wr(8'h00, 32'h0000_0005);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        c1 = rd;
        repeat (36) @(posedge i_mclk);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        check("divide by 4 rate", rd - c1, 32'h0000_000A);
        wr(8'h00, 32'h0000_0000);
        wr(8'h18, 32'h0000_0302);
        wr(8'h14, 32'h0000_0102);
        wr(8'h1C, 32'h0000_0100);
        wr(8'h0C, 32'h0000_0001);
        wr(8'h10, 32'h0000_0001);
        wr(8'h00, 32'h0000_0001);
        h0 = hi_match_seen;
        event_source_model_i.send_count(1);
        rd_chk("split bytes", 8'h14, 32'h0000_0001);
        check("split high match", hi_match_seen - h0, 32'h0000_0001);
    endtask
    // reset dropped while the counter runs with a pending buffer value
    task automatic t_mid_reset();
        wr(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        wr(8'h28, 32'h0000_0055);
        repeat (3) @(posedge i_mclk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rd_chk("reset count", 8'h14, 32'h0000_0000);
        rd_chk("reset enable", 8'h00, 32'h0000_0000);
        rd_chk("reset period", 8'h18, 32'h0000_0000);
        rd_chk("reset valid", 8'h08, 32'h0000_0000);
        rd_chk("reset split", 8'h0C, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_arst_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0000_0000;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        t_reset();
        t_buffers();
        t_events();
        t_restart_compare();
        t_prescale_split();
        t_mid_reset();
        results();
    end
endmodule
